// >>> hw/scol_synth_ctrl.sv
// Synthesizer control: clock output, lock flag, VCO settings, divider banks and mode decode
// Behaviour
// - With the clock-output enable set, a sub-multiple of the reference, from half of it downward, is driven on the clock pin.
// - The clock-output divide field picks the division applied before the clock pin.
// - Clock output is on after reset and runs in every mode but sleep.
// - The lock flag reads back and stays set until software writes a one to its bit.
// - With the lock-pin enable set, the lock flag is also driven on the lock pin.
// - A two-bit VCO tank trim field starts at zero and is handed to the VCO.
// - Two divider sets of R, P and S live in six byte registers at indices 6 to 11.
// - In FSK the synthesizer uses the selected R, P and S with no carrier offset.
// - In OOK transmit the carrier is placed below the synthesized frequency by the deviation.
// - Mode code 100 enables transmit.
// - Mode code 011 enables receive.
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "scol_defs.svh"
module scol_synth_ctrl (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        lock_detect_in,
	output logic             ref_clk_out,
	output logic             lock_pin_out,
	output logic             irq,
	output logic             tx_enable,
	output logic             rx_enable,
	output logic             ook_offset_active,
	output logic      [2:0]  vco_band_select,
	output logic      [1:0]  vco_tank_trim,
	output logic      [7:0]  deviation_setting,
	output logic      [7:0]  synth_r,
	output logic      [7:0]  synth_p,
	output logic      [7:0]  synth_s
);
	scol_div_if div ();

	logic       ref_clock_out_enable;
	logic [4:0] ref_clock_out_divide;
	logic       lock_pin_enable;
	logic       set_sel_r;
	logic [2:0] operating_mode_select;
	logic       ook_sel_r;
	logic       synth_lock_flag;
	logic [1:0] istat_r;
	logic [1:0] imask_r;
	logic       a_valid_r;
	logic       a_write_r;
	logic [5:0] a_idx_r;
	logic       rd_mem_r;
	logic [31:0] rdata_r;
	logic       lk_s1_r;
	logic       lk_s2_r;
	logic       lk_d_r;
	logic [4:0] cnt_r;
	logic       clk_out_r;
	logic       lock_pin_r;

	// True for a mapped word index in the divider byte range
	function automatic logic is_div(input logic [5:0] idx);
		return idx >= `SCOL_IDX_DIV_FIRST && idx <= `SCOL_IDX_DIV_LAST;
	endfunction

	// Word index of a byte address; upper bits must be zero to be mapped
	function automatic logic [5:0] word_idx(input logic [31:0] a);
		return (a[31:8] == 24'h000000) ? a[7:2] : 6'h3F;
	endfunction

	logic       acc;
	logic [5:0] cur_idx;
	logic       wr_ph;
	logic       rd_ph_acc;
	logic       flag_clr;
	logic       lk_rise;
	logic       lk_fall;
	logic       clk_on;

	assign acc       = hsel && htrans[1] && hready;
	assign cur_idx   = word_idx(haddr);
	assign wr_ph     = a_valid_r && a_write_r;
	assign rd_ph_acc = acc && !hwrite;
	assign hreadyout = 1'b1;  // Every access completes with no wait state
	assign hresp     = 1'b0;
	assign lk_rise   = lk_s2_r && !lk_d_r;
	assign lk_fall   = !lk_s2_r && lk_d_r;
	// W1C on the lock flag bit
	assign flag_clr  = wr_ph && a_idx_r == `SCOL_IDX_LOCK && hwdata[`SCOL_LOCKFLAG_BIT];
	// clock output never runs in sleep
	assign clk_on    = ref_clock_out_enable && operating_mode_select != scol_pkg::SCOL_MODE_SLEEP;

	// Address phase capture; the data phase follows on the next cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_valid_r <= 1'b0;
			a_write_r <= 1'b0;
			a_idx_r   <= 6'h00;
			rd_mem_r  <= 1'b0;
		end else begin
			a_valid_r <= acc;
			a_write_r <= hwrite;
			a_idx_r   <= cur_idx;
			rd_mem_r  <= rd_ph_acc && is_div(cur_idx);
		end
	end

	// Read word latched in the address phase; unmapped indices read zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_r <= 32'h00000000;
		end else if (rd_ph_acc) begin
			rdata_r <= 32'h00000000;
			case (cur_idx)
				`SCOL_IDX_CTRL: begin
					rdata_r[`SCOL_CLKEN_BIT]                  <= ref_clock_out_enable;
					rdata_r[`SCOL_CLKDIV_MSB:`SCOL_CLKDIV_LSB] <= ref_clock_out_divide;
					rdata_r[`SCOL_LOCKPIN_BIT]                <= lock_pin_enable;
					rdata_r[`SCOL_SETSEL_BIT]                 <= set_sel_r;
				end
				`SCOL_IDX_MODE: begin
					rdata_r[`SCOL_MODE_MSB:`SCOL_MODE_LSB] <= operating_mode_select;
					rdata_r[`SCOL_BAND_MSB:`SCOL_BAND_LSB] <= vco_band_select;
					rdata_r[`SCOL_TRIM_MSB:`SCOL_TRIM_LSB] <= vco_tank_trim;
					rdata_r[`SCOL_OOK_BIT]                 <= ook_sel_r;
					rdata_r[`SCOL_DEV_MSB:`SCOL_DEV_LSB]   <= deviation_setting;
				end
				`SCOL_IDX_LOCK: begin
					rdata_r[`SCOL_LOCKFLAG_BIT] <= synth_lock_flag;
					rdata_r[`SCOL_LOCKLIVE_BIT] <= lk_s2_r;
				end
				`SCOL_IDX_ISTAT: rdata_r[1:0] <= istat_r;
				`SCOL_IDX_IMASK: rdata_r[1:0] <= imask_r;
				default: rdata_r <= 32'h00000000;
			endcase
		end
	end

	// Divider bytes come straight from the store's registered read port
	assign hrdata = rd_mem_r ? {24'h000000, div.rdata} : rdata_r;

	// Control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_clock_out_enable <= `SCOL_CLKEN_RST;
			ref_clock_out_divide <= `SCOL_CLKDIV_RST;
			lock_pin_enable      <= 1'b0;
			set_sel_r            <= 1'b0;
		end else if (wr_ph && a_idx_r == `SCOL_IDX_CTRL) begin
			ref_clock_out_enable <= hwdata[`SCOL_CLKEN_BIT];
			ref_clock_out_divide <= hwdata[`SCOL_CLKDIV_MSB:`SCOL_CLKDIV_LSB];
			lock_pin_enable      <= hwdata[`SCOL_LOCKPIN_BIT];
			// set select moves only on this write
			set_sel_r            <= hwdata[`SCOL_SETSEL_BIT];
		end
	end

	// Mode register; reset lands in standby so the clock output is live
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			operating_mode_select <= `SCOL_MODE_STBY_CODE;
			vco_band_select       <= `SCOL_BAND_RST;
			vco_tank_trim         <= `SCOL_TRIM_RST;
			ook_sel_r             <= 1'b0;
			deviation_setting     <= `SCOL_DEV_RST;
		end else if (wr_ph && a_idx_r == `SCOL_IDX_MODE) begin
			operating_mode_select <= hwdata[`SCOL_MODE_MSB:`SCOL_MODE_LSB];
			// band is passed to the VCO as written
			vco_band_select       <= hwdata[`SCOL_BAND_MSB:`SCOL_BAND_LSB];
			// trim starts at zero, each step moves the tuning voltage
			vco_tank_trim         <= hwdata[`SCOL_TRIM_MSB:`SCOL_TRIM_LSB];
			ook_sel_r             <= hwdata[`SCOL_OOK_BIT];
			deviation_setting     <= hwdata[`SCOL_DEV_MSB:`SCOL_DEV_LSB];
		end
	end

	// Interrupt mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			imask_r <= 2'h0;
		end else if (wr_ph && a_idx_r == `SCOL_IDX_IMASK) begin
			imask_r <= hwdata[1:0];
		end
	end

	// divider bytes at indices 6 to 11 go to the byte store
	assign div.we      = wr_ph && is_div(a_idx_r);
	assign div.waddr   = 3'(a_idx_r - `SCOL_IDX_DIV_FIRST);
	assign div.wdata   = hwdata[7:0];
	assign div.raddr   = 3'(cur_idx - `SCOL_IDX_DIV_FIRST);
	assign div.set_sel = set_sel_r;

	scol_div_mem u_mem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.div     (div)
	);

	// the selected set drives the synthesizer dividers
	assign synth_r = div.active.r;
	assign synth_p = div.active.p;
	assign synth_s = div.active.s;

	// Lock detect comes from the analog loop, so two flops before use
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lk_s1_r <= 1'b0;
			lk_s2_r <= 1'b0;
			lk_d_r  <= 1'b0;
		end else begin
			lk_s1_r <= lock_detect_in;
			lk_s2_r <= lk_s1_r;
			lk_d_r  <= lk_s2_r;
		end
	end

	// a rising lock edge wins over a same-cycle clear
	// flag holds until a one is written to its bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			synth_lock_flag <= 1'b0;
		end else if (lk_rise) begin
			synth_lock_flag <= 1'b1;
		end else if (flag_clr) begin
			synth_lock_flag <= 1'b0;
		end
	end

	// Sticky interrupt events; a read clears them but a new event wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			istat_r <= 2'h0;
		end else begin
			if (rd_ph_acc && cur_idx == `SCOL_IDX_ISTAT) begin
				istat_r <= 2'h0;
			end
			if (lk_rise) begin
				istat_r[`SCOL_IRQ_GAIN_BIT] <= 1'b1;
			end
			if (lk_fall) begin
				istat_r[`SCOL_IRQ_LOST_BIT] <= 1'b1;
			end
		end
	end

	assign irq = |(istat_r & imask_r);

	// lock pin mirrors the flag while enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_pin_r <= 1'b0;
		end else begin
			lock_pin_r <= lock_pin_enable && synth_lock_flag;
		end
	end

	assign lock_pin_out = lock_pin_r;

	// toggle divider gives the reference over 2*(divide+1)
	// the divide field sets the half period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r     <= 5'h00;
			clk_out_r <= 1'b0;
		end else if (!clk_on) begin
			cnt_r     <= 5'h00;
			clk_out_r <= 1'b0;
		end else if (cnt_r >= ref_clock_out_divide) begin
			cnt_r     <= 5'h00;
			clk_out_r <= !clk_out_r;
		end else begin
			cnt_r     <= 5'(cnt_r + 5'h01);
		end
	end

	assign ref_clk_out = clk_out_r;

	// OOK transmit offsets the carrier down by the deviation
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_enable         <= 1'b0;
			rx_enable         <= 1'b0;
			ook_offset_active <= 1'b0;
		end else begin
			tx_enable         <= operating_mode_select == scol_pkg::SCOL_MODE_TX;
			rx_enable         <= operating_mode_select == scol_pkg::SCOL_MODE_RX;
			ook_offset_active <= operating_mode_select == scol_pkg::SCOL_MODE_TX && ook_sel_r;
		end
	end

	// Checks on the block's outputs and on its lock flag and set select registers
	a_clk_idle_low: assert property (@(posedge hclk) disable iff (!hresetn)
		!clk_on |=> !ref_clk_out)
		else $error("clock output not low while disabled");
	a_clk_toggle_point: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_on && cnt_r == ref_clock_out_divide) |=> ref_clk_out != $past(ref_clk_out))
		else $error("clock output missed its toggle");
	a_clk_half_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_on && cnt_r < ref_clock_out_divide) |=> $stable(ref_clk_out))
		else $error("clock output toggled early");
	a_lock_rise_set: assert property (@(posedge hclk) disable iff (!hresetn)
		lk_rise |=> synth_lock_flag)
		else $error("lock edge did not set flag");
	a_lock_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(synth_lock_flag && !flag_clr) |=> synth_lock_flag)
		else $error("lock flag dropped without clear");
	a_lock_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(flag_clr && !lk_rise) |=> !synth_lock_flag)
		else $error("lock flag not cleared");
	a_lock_pin_follow: assert property (@(posedge hclk) disable iff (!hresetn)
		(lock_pin_enable && lk_rise) |=> ##1 lock_pin_out)
		else $error("lock pin not driven");
	a_tx_mode_on: assert property (@(posedge hclk) disable iff (!hresetn)
		(operating_mode_select == scol_pkg::SCOL_MODE_TX) |=> (tx_enable && !rx_enable))
		else $error("transmit not entered");
	a_rx_mode_on: assert property (@(posedge hclk) disable iff (!hresetn)
		(operating_mode_select == scol_pkg::SCOL_MODE_RX) |=> (rx_enable && !tx_enable))
		else $error("receive not entered");
	a_set_only_write: assert property (@(posedge hclk) disable iff (!hresetn)
		$changed(set_sel_r) |-> $past(wr_ph && a_idx_r == `SCOL_IDX_CTRL))
		else $error("set select changed without write");
	a_ook_offset_tx: assert property (@(posedge hclk) disable iff (!hresetn)
		ook_offset_active |-> (tx_enable && $past(ook_sel_r)))
		else $error("offset outside OOK transmit");

	c_clk_running: cover property (@(posedge hclk) disable iff (!hresetn)
		clk_on ##1 ref_clk_out ##1 !ref_clk_out);
	c_lock_set_clear: cover property (@(posedge hclk) disable iff (!hresetn)
		lk_rise ##[1:20] flag_clr);
	c_set_swap: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(set_sel_r));
	c_irq_raise: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(irq));
endmodule

// >>> hw/scol_defs.svh
// Register indices, field positions, reset values and mode codes of the synthesizer control block
`ifndef SCOL_DEFS_SVH
`define SCOL_DEFS_SVH
// Word indices; byte address is four times the index
`define SCOL_IDX_CTRL      6'h00
`define SCOL_IDX_MODE      6'h01
`define SCOL_IDX_LOCK      6'h02
`define SCOL_IDX_ISTAT     6'h03
`define SCOL_IDX_IMASK     6'h04
`define SCOL_IDX_DIV_FIRST 6'h06
`define SCOL_IDX_DIV_LAST  6'h0B
// Control register fields
`define SCOL_CLKEN_BIT     0
`define SCOL_CLKDIV_LSB    8
`define SCOL_CLKDIV_MSB    12
`define SCOL_LOCKPIN_BIT   16
`define SCOL_SETSEL_BIT    20
// Mode register fields
`define SCOL_MODE_LSB      0
`define SCOL_MODE_MSB      2
`define SCOL_BAND_LSB      4
`define SCOL_BAND_MSB      6
`define SCOL_TRIM_LSB      8
`define SCOL_TRIM_MSB      9
`define SCOL_OOK_BIT       12
`define SCOL_DEV_LSB       16
`define SCOL_DEV_MSB       23
// Lock register and interrupt bits
`define SCOL_LOCKFLAG_BIT  0
`define SCOL_LOCKLIVE_BIT  1
`define SCOL_IRQ_GAIN_BIT  0
`define SCOL_IRQ_LOST_BIT  1
// Reset values
`define SCOL_CLKEN_RST     1'b1
`define SCOL_CLKDIV_RST    5'h00
`define SCOL_TRIM_RST      2'h0
`define SCOL_BAND_RST      3'h0
`define SCOL_DEV_RST       8'h00
// Operating mode codes
`define SCOL_MODE_SLEEP_CODE 3'h0
`define SCOL_MODE_STBY_CODE  3'h1
`define SCOL_MODE_RX_CODE    3'h3
`define SCOL_MODE_TX_CODE    3'h4
`endif

// >>> hw/scol_pkg.sv
// Types shared by the synthesizer control block
`include "scol_defs.svh"
package scol_pkg;
	typedef enum logic [2:0] {
		SCOL_MODE_SLEEP = `SCOL_MODE_SLEEP_CODE,
		SCOL_MODE_STBY  = `SCOL_MODE_STBY_CODE,
		SCOL_MODE_RX    = `SCOL_MODE_RX_CODE,
		SCOL_MODE_TX    = `SCOL_MODE_TX_CODE
	} scol_mode_t;
	typedef struct packed {
		logic [7:0] r;
		logic [7:0] p;
		logic [7:0] s;
	} scol_div_set_t;
endpackage

// >>> hw/scol_div_if.sv
// Carrier between the control logic and the divider byte store
`timescale 1ns/1ps
interface scol_div_if;
	logic                    we;
	logic [2:0]              waddr;
	logic [7:0]              wdata;
	logic [2:0]              raddr;
	logic [7:0]              rdata;
	logic                    set_sel;
	scol_pkg::scol_div_set_t active;
	modport ctl (output we, waddr, wdata, raddr, set_sel, input rdata, active);
	modport mem (input we, waddr, wdata, raddr, set_sel, output rdata, active);
endinterface

// >>> hw/scol_div_mem.sv
// Six divider bytes, two sets of R, P and S, with registered read ports
`timescale 1ns/1ps
module scol_div_mem (
	input wire logic hclk,
	input wire logic hresetn,
	scol_div_if.mem  div
);
	logic [7:0] mem_r [0:5];

	// Byte store; index 0..2 first set, 3..5 second set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 6; i++) begin
				mem_r[i] <= 8'h00;
			end
		end else if (div.we && div.waddr < 3'h6) begin
			mem_r[div.waddr] <= div.wdata;
		end
	end

	// Bus read byte, one cycle after the address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div.rdata <= 8'h00;
		end else begin
			div.rdata <= (div.raddr < 3'h6) ? mem_r[div.raddr] : 8'h00;
		end
	end

	// Selected set to the synthesizer; both sets stay loaded so a swap lands one cycle after set_sel changes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div.active <= '0;
		end else if (div.set_sel) begin
			div.active <= {mem_r[3], mem_r[4], mem_r[5]};
		end else begin
			div.active <= {mem_r[0], mem_r[1], mem_r[2]};
		end
	end
endmodule

// >>> verif/scol_pll_model.sv
// Behavioural synthesizer side: lock detect source and clock output consumer
`timescale 1ns/1ps
module scol_pll_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       lock_req,
	input  wire logic       ref_clk_out,
	output logic            lock_detect_in,
	output logic      [7:0] half_len
);
	logic       prev_r;
	logic [7:0] cnt_r;

	// Lock level settles just after an edge, unrelated to any bus access
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_detect_in <= 1'b0;
		end else begin
			lock_detect_in <= lock_req;
		end
	end

	// Cycles between output changes; saturates so a stopped clock keeps its last figure
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_r   <= 1'b0;
			cnt_r    <= 8'h00;
			half_len <= 8'h00;
		end else begin
			prev_r <= ref_clk_out;
			if (ref_clk_out != prev_r) begin
				half_len <= cnt_r + 8'h01;
				cnt_r    <= 8'h00;
			end else if (cnt_r != 8'hFF) begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end
endmodule

// >>> verif/tb_synth_clock_out_lock_control.sv
// Self-checking bench for the synthesizer control block
`timescale 1ns/1ps
`include "scol_defs.svh"
module tb_synth_clock_out_lock_control;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        lock_req;
	logic        lock_detect_in;
	logic        ref_clk_out;
	logic        lock_pin_out;
	logic        irq;
	logic        tx_enable;
	logic        rx_enable;
	logic        ook_offset_active;
	logic [2:0]  vco_band_select;
	logic [1:0]  vco_tank_trim;
	logic [7:0]  deviation_setting;
	logic [7:0]  synth_r;
	logic [7:0]  synth_p;
	logic [7:0]  synth_s;
	logic [7:0]  half_len;
	int          n_fail;
	int          tests_run;

	scol_synth_ctrl DUT (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .lock_detect_in,
		.ref_clk_out, .lock_pin_out, .irq, .tx_enable, .rx_enable, .ook_offset_active,
		.vco_band_select, .vco_tank_trim, .deviation_setting, .synth_r, .synth_p, .synth_s
	);
	scol_pll_model pm (.hclk, .hresetn, .lock_req, .ref_clk_out, .lock_detect_in, .half_len);

	// Free-running 10 MHz clock
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bounded wait for hready; a stuck slave ends the run
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			if (n > 20) begin
				n_fail++;
				$display("CHECK FAILED hready expected 1 seen %b", hreadyout);
				end_sim;
			end
		end while (hreadyout !== 1'b1);
	endtask

	// Single AHB transfer: address phase held until hready, then data phase
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask

	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, {24'h000000, i, 2'h0}, d, q);
	endtask

	task automatic rdc(input string what, input logic [5:0] i, input logic [31:0] e);
		logic [31:0] q;
		ahb(1'b0, {24'h000000, i, 2'h0}, 32'h00000000, q);
		chk(what, q, e);
	endtask

	// Outputs are judged at the falling edge, well clear of register updates
	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask

	task automatic t_reset;
		rdc("ctrl", `SCOL_IDX_CTRL, 32'h00000001);
		rdc("mode", `SCOL_IDX_MODE, 32'h00000001);
		rdc("lock", `SCOL_IDX_LOCK, 32'h00000000);
		settle(4);
		chk("half", 32'(half_len), 32'h00000001);
		chk("trim", 32'(vco_tank_trim), 32'h00000000);
		$display("test reset done");
	endtask

	task automatic t_clkout;
		logic [4:0] dv [3] = '{5'h00, 5'h02, 5'h1F};
		foreach (dv[i]) begin
			wr(`SCOL_IDX_CTRL, {19'h00000, dv[i], 8'h01});
			settle(100);
			chk("half", 32'(half_len), 32'(dv[i]) + 32'h00000001);
		end
		wr(`SCOL_IDX_CTRL, 32'h00000000);
		settle(3);
		chk("off", 32'(ref_clk_out), 32'h00000000);
		settle(1);
		chk("off", 32'(ref_clk_out), 32'h00000000);
		wr(`SCOL_IDX_CTRL, 32'h00000001);
		wr(`SCOL_IDX_MODE, 32'h00000000);
		settle(3);
		chk("sleep", 32'(ref_clk_out), 32'h00000000);
		settle(1);
		chk("sleep", 32'(ref_clk_out), 32'h00000000);
		wr(`SCOL_IDX_MODE, 32'h00000001);
		settle(10);
		chk("half", 32'(half_len), 32'h00000001);
		$display("test clock out done");
	endtask

	task automatic t_mode;
		for (int b = 0; b < 6; b++) begin
			wr(`SCOL_IDX_MODE, {8'h00, 8'hA5, 3'h0, 1'b1, 2'h0, 2'h3, 1'b0, 3'(b), 1'b0, 3'h4});
			settle(2);
			chk("band", 32'(vco_band_select), 32'(b));
		end
		chk("tx", 32'(tx_enable), 32'h00000001);
		chk("rx", 32'(rx_enable), 32'h00000000);
		chk("ook", 32'(ook_offset_active), 32'h00000001);
		chk("dev", 32'(deviation_setting), 32'h000000A5);
		chk("trim", 32'(vco_tank_trim), 32'h00000003);
		wr(`SCOL_IDX_MODE, 32'h00000004);
		settle(2);
		chk("fsk", 32'(ook_offset_active), 32'h00000000);
		wr(`SCOL_IDX_MODE, 32'h00001003);
		settle(2);
		chk("rx", 32'(rx_enable), 32'h00000001);
		chk("tx", 32'(tx_enable), 32'h00000000);
		chk("ook", 32'(ook_offset_active), 32'h00000000);
		$display("test mode done");
	endtask

	task automatic t_lock;
		wr(`SCOL_IDX_IMASK, 32'h00000001);
		lock_req <= 1'b1;
		settle(6);
		chk("irq", 32'(irq), 32'h00000001);
		chk("pin", 32'(lock_pin_out), 32'h00000000);
		wr(`SCOL_IDX_CTRL, 32'h00010001);
		settle(2);
		chk("pin", 32'(lock_pin_out), 32'h00000001);
		rdc("lock", `SCOL_IDX_LOCK, 32'h00000003);
		wr(`SCOL_IDX_LOCK, 32'h00000001);
		settle(2);
		chk("pin", 32'(lock_pin_out), 32'h00000000);
		rdc("lock", `SCOL_IDX_LOCK, 32'h00000002);
		rdc("istat", `SCOL_IDX_ISTAT, 32'h00000001);
		rdc("istat", `SCOL_IDX_ISTAT, 32'h00000000);
		settle(1);
		chk("irq", 32'(irq), 32'h00000000);
		@(posedge hclk);
		lock_req <= 1'b0;
		settle(6);
		chk("mask", 32'(irq), 32'h00000000);
		rdc("istat", `SCOL_IDX_ISTAT, 32'h00000002);
		// Lock returns while the pin is enabled, so the pin must follow the new rise
		@(posedge hclk);
		lock_req <= 1'b1;
		settle(6);
		chk("pin", 32'(lock_pin_out), 32'h00000001);
		chk("irq", 32'(irq), 32'h00000001);
		$display("test lock done");
	endtask

	task automatic t_div;
		logic [7:0]  v [6] = '{8'h77, 8'h10, 8'h05, 8'hA9, 8'h20, 8'h0C};
		logic [31:0] q;
		// R within range, S below P plus one
		foreach (v[i]) wr(6'(`SCOL_IDX_DIV_FIRST + i), 32'(v[i]));
		settle(2);
		chk("r", 32'(synth_r), 32'(v[0]));
		chk("p", 32'(synth_p), 32'(v[1]));
		chk("s", 32'(synth_s), 32'(v[2]));
		rdc("byte", 6'h0A, 32'h00000020);
		wr(`SCOL_IDX_CTRL, 32'h00100001);
		settle(2);
		chk("r", 32'(synth_r), 32'(v[3]));
		chk("p", 32'(synth_p), 32'(v[4]));
		chk("s", 32'(synth_s), 32'(v[5]));
		rdc("gap", 6'h05, 32'h00000000);
		ahb(1'b1, 32'h00000100, 32'hFFFFFFFF, q);
		chk("hresp", 32'(hresp), 32'h00000000);
		rdc("ctrl", `SCOL_IDX_CTRL, 32'h00100001);
		$display("test dividers done");
	endtask

	initial begin
		hresetn   = 1'b0;
		hsel      = 1'b0;
		haddr     = 32'h00000000;
		htrans    = 2'h0;
		hwrite    = 1'b0;
		hsize     = 3'h2;
		hwdata    = 32'h00000000;
		lock_req  = 1'b0;
		n_fail    = 0;
		tests_run = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_clkout;
		t_mode;
		t_lock;
		t_div;
		end_sim;
	end
endmodule
